// File: dv/elcsr_host_model.sv
/*
 * Host processor model for the parallel port of the register bank.
 * Assumes the bench calls wr and rd one at a time and that i_mclk is
 * the bank's own clock; strobes, address and write data change only at its falling edge.
 */
`timescale 1ns/1ps
module elcsr_host_model (
	input  wire logic             i_mclk,
	input  wire logic [7:0]       i_dev_data,
	input  wire logic             i_dev_oe_n,
	output elcsr_pkg::elcsr_pbus_t o_pbus
);
	import elcsr_pkg::*;
	elcsr_pbus_t drv = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
	logic        host_en = 1'b0;
	logic [7:0]  last = 8'h00;
	logic        oe_seen = 1'b0;

	// ==========================================================
	// bus wire
	// undriven bus shows a changing pattern, never a stale copy
	always_comb begin
		o_pbus = drv;
		if (!i_dev_oe_n) begin
			o_pbus.data = i_dev_data;
		end else if (!host_en) begin
			o_pbus.data = ~last;
		end
	end

	always @(posedge i_mclk) begin
		last <= o_pbus.data;
		if (!i_dev_oe_n) begin
			oe_seen <= 1'b1;
		end
	end

	// ==========================================================
	// cycles
	task automatic cyc(input int n);
		repeat (n) @(negedge i_mclk);
	endtask

	// address held through the whole access, well past the latch window
	task automatic addr_phase(input logic [3:0] a);
		cyc(1);
		drv.cs_n = 1'b0;
		drv.ale = 1'b1;
		drv.addr = a;
		cyc(2);
		drv.ale = 1'b0;
		cyc(4);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		addr_phase(a);
		host_en = 1'b1;
		drv.data = (a == ADDR_CMD1) ? {2'b00, d[5:0]} : d;
		drv.wr_n = 1'b0;
		cyc(6);
		drv.wr_n = 1'b1;
		cyc(2);
		host_en = 1'b0;
		cyc(4);
		drv.cs_n = 1'b1;
		cyc(4);
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		addr_phase(a);
		drv.rd_n = 1'b0;
		cyc(6);
		d = o_pbus.data;
		drv.rd_n = 1'b1;
		cyc(6);
		drv.cs_n = 1'b1;
		cyc(2);
	endtask
endmodule

// File: dv/elcsr_regs_test.sv
/*
 * Self-checking bench for the register bank: port traffic through the
 * host model, alarm and mask levels driven directly.
 * Assumes fixed port latencies, so every wait is a fixed cycle count.
 */
`timescale 1ns/1ps
module elcsr_regs_test;
	import elcsr_pkg::*;
	localparam int LZS = 40;
	logic                      i_mclk;
	logic                      i_sys_rst;
	elcsr_pbus_t               pbus;
	elcsr_alarm_t [NUM_CH-1:0] live;
	elcsr_alarm_t [NUM_CH-1:0] mask;
	logic [7:0]                dout;
	logic                      oe_n;
	logic                      rdy;
	int                        n_rdy_low;
	logic                      int_n;
	logic [3:0]                mute;
	logic [12:0]               lim;
	elcsr_line_cfg_t           cfg;
	int                        failures;
	int                        n_checks;

	elcsr_regs #(.LOS_ZEROS_STD(LZS)) elcsr_regs_inst (
		.i_mclk          (i_mclk),
		.i_sys_rst       (i_sys_rst),
		.i_pbus          (pbus),
		.i_alarm_live    (live),
		.i_alarm_mask    (mask),
		.o_data_out      (dout),
		.o_data_oe_n     (oe_n),
		.o_rdy           (rdy),
		.o_int_n         (int_n),
		.o_rx_mute       (mute),
		.o_los_zero_limit(lim),
		.o_line_cfg      (cfg)
	);

	elcsr_host_model elcsr_host_model_inst (
		.i_mclk    (i_mclk),
		.i_dev_data(dout),
		.i_dev_oe_n(oe_n),
		.o_pbus    (pbus)
	);

	always #10 i_mclk = ~i_mclk;

	// one low cycle of ready per recognised strobe
	always @(negedge i_mclk) begin
		if (!rdy) begin
			n_rdy_low++;
		end
	end

	// ==========================================================
	// helpers
	task automatic cyc(input int n);
		repeat (n) @(negedge i_mclk);
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		elcsr_host_model_inst.wr(a, d);
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		elcsr_host_model_inst.rd(a, d);
	endtask

	function automatic elcsr_line_cfg_t exp_cfg(input logic [7:0] c0, input logic [7:0] c1);
		elcsr_line_cfg_t e;
		e.single_rail = c0[7];
		e.hdb3_sel = c0[7] & ~c0[2];
		e.ami_sel = c0[7] & c0[2];
		e.retime_bypass = c0[6];
		e.recovery_enable = ~c0[6];
		e.rx_rise_edge = c0[5];
		e.tx_rise_edge = c0[4];
		e.active_low = c0[3];
		e.store_depth_64 = c1[5];
		e.jitter_rx = c1[4] & ~c1[3];
		e.jitter_tx = c1[3] & ~c1[4];
		e.tristate = c1[0];
		e.core_reset = c0[0];
		return e;
	endfunction

	// ==========================================================
	// scenarios
	task automatic t_reset;
		logic [3:0] adr [7] = '{ADDR_CMD0, ADDR_CMD1, ADDR_CH0, ADDR_CH1, ADDR_CH2, ADDR_CH3, 4'h3};
		logic [7:0] d;
		chk(16'(cfg), 16'(exp_cfg(8'h00, 8'h00)));
		chk(16'(lim), 16'(LZS));
		chk(16'({int_n, mute}), 16'h10);
		for (int i = 0; i < 7; i++) begin
			rd(adr[i], d);
			chk(16'(d), 16'h00);
		end
		chk(16'(n_rdy_low), 16'h7);
		$display("test reset done");
	endtask

	task automatic t_cfg;
		logic [7:0] v0 [8] = '{8'h80, 8'h84, 8'h04, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02};
		logic [7:0] v1 [8] = '{8'h20, 8'h10, 8'h08, 8'h18, 8'h04, 8'h02, 8'h00, 8'h00};
		logic [7:0] d;
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_CMD0, v0[i]);
			wr(ADDR_CMD1, v1[i]);
			rd(ADDR_CMD0, d);
			chk(16'(d), 16'(v0[i]));
			rd(ADDR_CMD1, d);
			chk(16'(d), 16'(v1[i]));
			chk(16'(cfg), 16'(exp_cfg(v0[i], v1[i])));
			chk(16'(lim), v1[i][1] ? 16'h1000 : 16'(LZS));
		end
		$display("test cfg done");
	endtask

	// each channel exercises a different alarm bit
	task automatic t_alarm;
		logic [3:0] adr [4] = '{ADDR_CH0, ADDR_CH1, ADDR_CH2, ADDR_CH3};
		logic [3:0] b;
		logic [7:0] d;
		wr(ADDR_CMD1, 8'h04);
		wr(ADDR_CMD0, 8'h02);
		for (int c = 0; c < 4; c++) begin
			b = 4'h8 >> c;
			mask = '0;
			live[c] = b;
			cyc(8);
			chk(16'(int_n), 16'h1);
			mask[c] = b;
			cyc(4);
			chk(16'(int_n), 16'h0);
			chk(16'(mute), 16'(c == 1 ? 4'h2 : 4'h0));
			wr(ADDR_CMD0, 8'h00);
			chk(16'(int_n), 16'h1);
			wr(ADDR_CMD0, 8'h02);
			wr(adr[c], 8'hFF);
			rd(adr[c], d);
			chk(16'(d), 16'({b, b}));
			chk(16'(int_n), 16'h1);
			rd(adr[c], d);
			chk(16'(d), 16'({b, 4'h0}));
			live[c] = 4'h0;
			cyc(8);
			chk(16'(int_n), 16'h0);
			rd(adr[c], d);
			chk(16'(d), 16'({4'h0, b}));
		end
		$display("test alarm done");
	endtask

	task automatic t_swrst;
		logic [7:0] d;
		wr(ADDR_CMD0, 8'h01);
		chk(16'(cfg.core_reset), 16'h1);
		// host holds the bit past 10 us (500 cycles)
		cyc(510);
		rd(ADDR_CMD0, d);
		chk(16'(d), 16'h01);
		rd(ADDR_CMD1, d);
		chk(16'(d), 16'h04);
		wr(ADDR_CMD0, 8'h00);
		chk(16'(cfg.core_reset), 16'h0);
		$display("test software reset done");
	endtask

	task automatic t_tristate;
		logic [7:0] d;
		live[2] = 4'h1;
		mask[2] = 4'h1;
		wr(ADDR_CMD0, 8'h02);
		elcsr_host_model_inst.oe_seen = 1'b0;
		rd(ADDR_CMD0, d);
		chk(16'({elcsr_host_model_inst.oe_seen, d}), 16'h102);
		chk(16'(int_n), 16'h0);
		wr(ADDR_CMD1, 8'h01);
		chk(16'({cfg.tristate, int_n}), 16'h3);
		elcsr_host_model_inst.oe_seen = 1'b0;
		rd(ADDR_CMD1, d);
		chk(16'(elcsr_host_model_inst.oe_seen), 16'h0);
		wr(ADDR_CMD1, 8'h00);
		chk(16'(int_n), 16'h0);
		rd(ADDR_CMD1, d);
		chk(16'(d), 16'h00);
		$display("test tristate done");
	endtask

	task automatic t_hwrst;
		logic [7:0] d;
		wr(ADDR_CMD0, 8'hA4);
		wr(ADDR_CMD1, 8'h3C);
		i_sys_rst = 1'b1;
		cyc(3);
		chk(16'(cfg), 16'(LINE_CFG_RST));
		i_sys_rst = 1'b0;
		cyc(2);
		chk(16'(cfg), 16'(exp_cfg(8'h00, 8'h00)));
		rd(ADDR_CMD0, d);
		chk(16'(d), 16'h00);
		rd(ADDR_CMD1, d);
		chk(16'(d), 16'h00);
		$display("test mid-run reset done");
	endtask

	// ==========================================================
	// run
	task automatic final_report;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		#1000000;
		failures++;
		final_report;
	end

	initial begin
		i_mclk = 1'b0;
		i_sys_rst = 1'b1;
		live = '0;
		mask = '0;
		failures = 0;
		n_checks = 0;
		n_rdy_low = 0;
		cyc(10);
		i_sys_rst = 1'b0;
		cyc(2);
		t_reset;
		t_cfg;
		t_alarm;
		t_swrst;
		t_tristate;
		t_hwrst;
		final_report;
	end
endmodule

// File: shared/elcsr_pkg.sv
/*
 * Shared constants and carrier types for the quad E1 line-interface
 * control/status register bank.
 * Assumes a single host-interface clock; all channel alarm sources and
 * parallel-port pins are asynchronous to it.
 */
package elcsr_pkg;

	// ==========================================================
	// sizes
	localparam int NUM_CH  = 4;
	localparam int ADDR_W  = 4;
	localparam int DATA_W  = 8;
	localparam int LOS_W   = 13;
	localparam int SYNC_N  = 2;

	// ==========================================================
	// parallel-port register addresses
	localparam logic [ADDR_W-1:0] ADDR_CMD0 = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_CMD1 = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_CH0  = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_CH1  = 4'h5;
	localparam logic [ADDR_W-1:0] ADDR_CH2  = 4'h8;
	localparam logic [ADDR_W-1:0] ADDR_CH3  = 4'hB;

	// ==========================================================
	// reset and default values
	localparam logic [DATA_W-1:0] CMD0_RST    = 8'h00;
	localparam logic [DATA_W-1:0] CMD1_RST    = 8'h00;
	localparam logic [DATA_W-1:0] UNMAPPED_RD = 8'h00;
	localparam logic [LOS_W-1:0]  LOS_ZEROS_EXT     = 13'h1000;
	localparam int                LOS_ZEROS_STD_DEF = 32;

	// ==========================================================
	// register layouts, msb first
	typedef struct packed {
		logic rail_format_select;
		logic unretimed_receive_select;
		logic receive_output_edge_select;
		logic transmit_sample_edge_select;
		logic data_polarity_select;
		logic line_code_select;
		logic global_interrupt_enable;
		logic software_reset_bit;
	} elcsr_cmd0_t;

	typedef struct packed {
		logic [1:0] reserved;
		logic       elastic_store_depth_select;
		logic       receive_jitter_path_select;
		logic       transmit_jitter_path_select;
		logic       receive_mute_on_signal_loss;
		logic       extended_signal_loss_count;
		logic       output_tristate_test;
	} elcsr_cmd1_t;

	typedef struct packed {
		logic driver_fault;
		logic signal_loss;
		logic code_violation;
		logic transmit_clock_loss;
	} elcsr_alarm_t;

	typedef struct packed {
		elcsr_alarm_t live;
		elcsr_alarm_t latched;
	} elcsr_status_t;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic              cs_n;
		logic              rd_n;
		logic              wr_n;
		logic              ale;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} elcsr_pbus_t;

	typedef struct packed {
		logic single_rail;
		logic hdb3_sel;
		logic ami_sel;
		logic retime_bypass;
		logic recovery_enable;
		logic rx_rise_edge;
		logic tx_rise_edge;
		logic active_low;
		logic store_depth_64;
		logic jitter_rx;
		logic jitter_tx;
		logic tristate;
		logic core_reset;
	} elcsr_line_cfg_t;

	localparam elcsr_line_cfg_t LINE_CFG_RST = '{core_reset: 1'b1, default: 1'b0};

endpackage

// File: verilog/elcsr_chan_status.sv
/*
 * One channel's alarm status register: live mirror plus change latches.
 * Assumes i_live is already synchronised to i_mclk and i_clear is a
 * one-cycle pulse per bit from the read logic.
 */
`timescale 1ns/1ps
module elcsr_chan_status (
	input  wire logic                  i_mclk,
	input  wire logic                  i_sys_rst,
	input  wire elcsr_pkg::elcsr_alarm_t i_live,
	input  wire elcsr_pkg::elcsr_alarm_t i_clear,
	output elcsr_pkg::elcsr_alarm_t        o_live,
	output elcsr_pkg::elcsr_alarm_t        o_latched
);
	import elcsr_pkg::*;

	elcsr_alarm_t live_r, live_nxt;
	elcsr_alarm_t latched_r, latched_nxt;
	elcsr_alarm_t change;

	// ==========================================================
	// next state
	always_comb begin
		live_nxt    = i_live;
		change      = i_live ^ live_r;
		// a change in the clearing cycle survives: set beats clear
		latched_nxt = (latched_r & ~i_clear) | change;
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			live_r    <= '0;
			latched_r <= '0;
		end else begin
			live_r    <= live_nxt;
			latched_r <= latched_nxt;
		end
	end

	assign o_live    = live_r;
	assign o_latched = latched_r;

	// ==========================================================
	// checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	a_latch_on_change:
	assert property ((i_live != live_r)
		|=> ((latched_r & $past(i_live ^ live_r)) == $past(i_live ^ live_r)))
		else $error("changed alarm not latched");
	a_live_mirror:
	assert property (##1 live_r == $past(i_live))
		else $error("live bit does not follow alarm");
	a_clear_on_read:
	assert property ((i_clear != '0 && i_live == live_r) |=> ((latched_r & $past(i_clear)) == '0))
		else $error("latched bit not cleared by read");

endmodule

// File: verilog/elcsr_regs.sv
/*
 * Host control/status register bank of a quad E1 line interface,
 * reached over the asynchronous parallel port (latch-enable timing).
 * Assumes port pins and live alarms are asynchronous to i_mclk, the alarm mask synchronous, and that
 * pad logic turns o_data_oe_n and o_line_cfg.tristate into pin drive.
 */
`timescale 1ns/1ps
module elcsr_regs #(
	parameter int LOS_ZEROS_STD = elcsr_pkg::LOS_ZEROS_STD_DEF
) (
	input  wire logic                                      i_mclk,
	input  wire logic                                      i_sys_rst,
	input  wire elcsr_pkg::elcsr_pbus_t                    i_pbus,
	input  wire elcsr_pkg::elcsr_alarm_t [elcsr_pkg::NUM_CH-1:0] i_alarm_live,
	input  wire elcsr_pkg::elcsr_alarm_t [elcsr_pkg::NUM_CH-1:0] i_alarm_mask,
	output logic [elcsr_pkg::DATA_W-1:0]                   o_data_out,
	output logic                                           o_data_oe_n,
	output logic                                           o_rdy,
	output logic                                           o_int_n,
	output logic [elcsr_pkg::NUM_CH-1:0]                   o_rx_mute,
	output logic [elcsr_pkg::LOS_W-1:0]                    o_los_zero_limit,
	output elcsr_pkg::elcsr_line_cfg_t                     o_line_cfg
);
	import elcsr_pkg::*;

	localparam logic [LOS_W-1:0] LOS_STD = LOS_W'(LOS_ZEROS_STD);

	// ==========================================================
	// address decode shared by read mux and read-clear
	function automatic logic [2:0] chan_decode(input logic [ADDR_W-1:0] a);
		unique case (a)
			ADDR_CH0: chan_decode = 3'h4;
			ADDR_CH1: chan_decode = 3'h5;
			ADDR_CH2: chan_decode = 3'h6;
			ADDR_CH3: chan_decode = 3'h7;
			default:  chan_decode = 3'h0;
		endcase
	endfunction

	// ==========================================================
	// pin synchronisers
	elcsr_pbus_t pbus_s1, pbus_s2, pbus_d;
	elcsr_alarm_t [NUM_CH-1:0] live_s1, live_s2;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			pbus_s1 <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
			pbus_s2 <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
			pbus_d  <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
			live_s1 <= '0;
			live_s2 <= '0;
		end else begin
			pbus_s1 <= i_pbus;
			pbus_s2 <= pbus_s1;
			pbus_d  <= pbus_s2;
			live_s1 <= i_alarm_live;
			live_s2 <= live_s1;
		end
	end

	// ==========================================================
	// strobe edges
	logic rd_start, rd_end, wr_start, wr_end;
	logic rd_busy_r, rd_busy_nxt, wr_busy_r, wr_busy_nxt;

	always_comb begin
		rd_start = !pbus_s2.cs_n && pbus_d.rd_n && !pbus_s2.rd_n && !rd_busy_r;
		wr_start = !pbus_s2.cs_n && pbus_d.wr_n && !pbus_s2.wr_n && !wr_busy_r;
		// cs may rise with the strobe, so the end edge trusts the busy flag
		rd_end   = rd_busy_r && pbus_s2.rd_n;
		wr_end   = wr_busy_r && pbus_s2.wr_n;
	end

	// ==========================================================
	// channel status registers
	elcsr_alarm_t [NUM_CH-1:0] ch_live, ch_latched, ch_clear;
	logic [ADDR_W-1:0]  addr_r, addr_nxt;
	logic [1:0]         rd_ch_r, rd_ch_nxt;
	logic               rd_chan_r, rd_chan_nxt;
	elcsr_alarm_t       snap_r, snap_nxt;

	generate
		for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
			// only the bits the host actually saw are cleared
			assign ch_clear[c] = (rd_end && rd_chan_r && rd_ch_r == 2'(c)) ? snap_r : '0;
			elcsr_chan_status u_status (
				.i_mclk    (i_mclk),
				.i_sys_rst (i_sys_rst),
				.i_live    (live_s2[c]),
				.i_clear   (ch_clear[c]),
				.o_live    (ch_live[c]),
				.o_latched (ch_latched[c])
			);
		end
	endgenerate

	// ==========================================================
	// command registers and bus engine
	elcsr_cmd0_t          cmd0_r, cmd0_nxt;
	elcsr_cmd1_t          cmd1_r, cmd1_nxt;
	logic [DATA_W-1:0]    dout_r, dout_nxt;
	logic                 oe_n_r, oe_n_nxt;
	logic                 rdy_r, rdy_nxt;
	logic [2:0]           rd_dec;

	always_comb begin
		addr_nxt    = pbus_s2.ale ? pbus_s2.addr : addr_r;
		cmd0_nxt    = cmd0_r;
		cmd1_nxt    = cmd1_r;
		dout_nxt    = dout_r;
		rd_busy_nxt = rd_busy_r;
		wr_busy_nxt = wr_busy_r;
		rd_ch_nxt   = rd_ch_r;
		rd_chan_nxt = rd_chan_r;
		snap_nxt    = snap_r;
		rd_dec      = chan_decode(addr_r);
		rdy_nxt     = !(rd_start || wr_start);
		if (rd_start) begin
			rd_busy_nxt = 1'b1;
			rd_chan_nxt = rd_dec[2];
			rd_ch_nxt   = rd_dec[1:0];
			snap_nxt    = ch_latched[rd_dec[1:0]];
			if (addr_r == ADDR_CMD0) begin
				dout_nxt = cmd0_r;
			end else if (addr_r == ADDR_CMD1) begin
				dout_nxt = cmd1_r;
			end else if (rd_dec[2]) begin
				dout_nxt = {ch_live[rd_dec[1:0]], ch_latched[rd_dec[1:0]]};
			end else begin
				dout_nxt = UNMAPPED_RD;
			end
		end else if (rd_end) begin
			rd_busy_nxt = 1'b0;
			rd_chan_nxt = 1'b0;
		end
		if (wr_start) begin
			wr_busy_nxt = 1'b1;
		end else if (wr_end) begin
			wr_busy_nxt = 1'b0;
			// data taken one sample before the strobe rose: zero hold time
			if (addr_r == ADDR_CMD0) begin
				cmd0_nxt = pbus_d.data;
			end else if (addr_r == ADDR_CMD1) begin
				cmd1_nxt = pbus_d.data;
			end
			// status addresses fall through untouched
		end
		oe_n_nxt = !(rd_busy_nxt && !cmd1_nxt.output_tristate_test);
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			cmd0_r    <= CMD0_RST;
			cmd1_r    <= CMD1_RST;
			addr_r    <= '0;
			dout_r    <= '0;
			oe_n_r    <= 1'b1;
			rdy_r     <= 1'b1;
			rd_busy_r <= 1'b0;
			wr_busy_r <= 1'b0;
			rd_ch_r   <= '0;
			rd_chan_r <= 1'b0;
			snap_r    <= '0;
		end else begin
			cmd0_r    <= cmd0_nxt;
			cmd1_r    <= cmd1_nxt;
			addr_r    <= addr_nxt;
			dout_r    <= dout_nxt;
			oe_n_r    <= oe_n_nxt;
			rdy_r     <= rdy_nxt;
			rd_busy_r <= rd_busy_nxt;
			wr_busy_r <= wr_busy_nxt;
			rd_ch_r   <= rd_ch_nxt;
			rd_chan_r <= rd_chan_nxt;
			snap_r    <= snap_nxt;
		end
	end

	// ==========================================================
	// line configuration, interrupt, muting
	elcsr_line_cfg_t           cfg_r, cfg_nxt;
	logic                      int_n_r, int_n_nxt;
	logic [NUM_CH-1:0]         mute_r, mute_nxt;
	logic [LOS_W-1:0]          los_r, los_nxt;
	logic                      int_pend;

	always_comb begin
		cfg_nxt.single_rail     = cmd0_r.rail_format_select;
		cfg_nxt.retime_bypass   = cmd0_r.unretimed_receive_select;
		cfg_nxt.recovery_enable = !cmd0_r.unretimed_receive_select;
		cfg_nxt.rx_rise_edge    = cmd0_r.receive_output_edge_select;
		cfg_nxt.tx_rise_edge    = cmd0_r.transmit_sample_edge_select;
		cfg_nxt.active_low      = cmd0_r.data_polarity_select;
		cfg_nxt.hdb3_sel        = cmd0_r.rail_format_select && !cmd0_r.line_code_select;
		cfg_nxt.ami_sel         = cmd0_r.rail_format_select && cmd0_r.line_code_select;
		cfg_nxt.core_reset      = cmd0_r.software_reset_bit;
		cfg_nxt.store_depth_64  = cmd1_r.elastic_store_depth_select;
		cfg_nxt.jitter_rx       = cmd1_r.receive_jitter_path_select &&
		                          !cmd1_r.transmit_jitter_path_select;
		cfg_nxt.jitter_tx       = cmd1_r.transmit_jitter_path_select &&
		                          !cmd1_r.receive_jitter_path_select;
		cfg_nxt.tristate        = cmd1_r.output_tristate_test;
		los_nxt = cmd1_r.extended_signal_loss_count ? LOS_ZEROS_EXT : LOS_STD;
		for (int c = 0; c < NUM_CH; c++) begin
			mute_nxt[c] = cmd1_r.receive_mute_on_signal_loss && ch_live[c].signal_loss;
		end
		int_pend = 1'b0;
		for (int c = 0; c < NUM_CH; c++) begin
			int_pend = int_pend || ((ch_latched[c] & i_alarm_mask[c]) != '0);
		end
		// open-drain style: released, not driven high, in test mode
		int_n_nxt = !(cmd0_r.global_interrupt_enable && int_pend) ||
		            cmd1_r.output_tristate_test;
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			cfg_r   <= LINE_CFG_RST;
			int_n_r <= 1'b1;
			mute_r  <= '0;
			los_r   <= LOS_STD;
		end else begin
			cfg_r   <= cfg_nxt;
			int_n_r <= int_n_nxt;
			mute_r  <= mute_nxt;
			los_r   <= los_nxt;
		end
	end

	assign o_line_cfg       = cfg_r;
	assign o_int_n          = int_n_r;
	assign o_rx_mute        = mute_r;
	assign o_los_zero_limit = los_r;
	assign o_data_out       = dout_r;
	assign o_data_oe_n      = oe_n_r;
	assign o_rdy            = rdy_r;

	// ==========================================================
	// checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	a_cmd_reset_zero:
	assert property ($fell(i_sys_rst) |-> cmd0_r == CMD0_RST && cmd1_r == CMD1_RST)
		else $error("command registers not zero after reset");
	a_soft_reset:
	assert property (cmd0_r.software_reset_bit [*2] |-> o_line_cfg.core_reset)
		else $error("core not held in reset by software bit");
	a_jitter_both:
	assert property ((cmd1_r.receive_jitter_path_select && cmd1_r.transmit_jitter_path_select)
		|=> !o_line_cfg.jitter_rx && !o_line_cfg.jitter_tx)
		else $error("jitter attenuator not disabled");
	a_mute_los:
	assert property ((cmd1_r.receive_mute_on_signal_loss && ch_live[1].signal_loss) |=> o_rx_mute[1])
		else $error("receive not muted on signal loss");
	a_los_extended:
	assert property (cmd1_r.extended_signal_loss_count |=> o_los_zero_limit == 13'h1000)
		else $error("extended loss count not 4096");
	a_tristate_bus:
	assert property (cmd1_r.output_tristate_test |=> o_data_oe_n && o_int_n)
		else $error("outputs driven in tristate test");
	a_int_gated:
	assert property (!cmd0_r.global_interrupt_enable |=> o_int_n)
		else $error("interrupt without global enable");
	a_int_raise:
	assert property ((cmd0_r.global_interrupt_enable && !cmd1_r.output_tristate_test &&
		(ch_latched[1] & i_alarm_mask[1]) != '0) |=> !o_int_n)
		else $error("masked latched alarm gives no interrupt");
	a_code_single:
	assert property ((o_line_cfg.hdb3_sel || o_line_cfg.ami_sel) |-> o_line_cfg.single_rail)
		else $error("line code active in dual rail");
	a_read_drive:
	assert property ((rd_start && addr_r == ADDR_CH2 && !cmd1_r.output_tristate_test)
		|=> !o_data_oe_n && !o_rdy &&
		o_data_out == {$past(ch_live[2]), $past(ch_latched[2])})
		else $error("status read not driven");
	a_status_no_write:
	assert property ((wr_end && chan_decode(addr_r) != 3'h0) |=> $stable(cmd0_r) && $stable(cmd1_r))
		else $error("status write changed a command register");

endmodule
